// ---- rtl/mfsb_pkg.sv ----
// Constants shared by the mode and fault status bank and its serial link.
// Function
// - Enable bit one enters active mode
// - Enable bit zero: standby, control bits cleared
// - Power-on reset starts in standby mode
// - Status bit 23 always reads one
// - Over-current sets flag, switches output off
// - Retry enable re-enables output after delay
// - Clock phase may force one retry
// - Supply over/under voltage flags, outputs off
// - Supply recovery reactivates outputs automatically
// - Thermal shutdown sets flag, outputs off
// - Shutdown flag held until reset bit
// - Temperature warning is information only
// - Start-up timer holds outputs, reports not-ready
// - Not-ready clears when start-up timer ends
// - Bit 0 is NOR of fault bits
package mfsb_pkg;
   localparam int          FRAME_BITS      = 24;
   localparam int          N_RETRY         = 5;
   // Input word fields.
   localparam int          IN_ENABLE       = 23;
   localparam int          IN_RETRY_HI     = 22;
   localparam int          IN_RETRY_LO     = 18;
   localparam int          IN_SELECT       = 0;
   localparam logic        SELECT_THIS_REG = 1'b1;
   // Status word fields.
   localparam int          STS_MARK        = 23;
   localparam int          STS_OVERVOLT    = 22;
   localparam int          STS_UNDERVOLT   = 21;
   localparam int          STS_THERMAL     = 20;
   localparam int          STS_WARNING     = 19;
   localparam int          STS_NOT_READY   = 18;
   localparam int          STS_NO_FAULT    = 0;
   localparam int          LOWER_BITS      = 17;
   // Reset values.
   localparam logic [5:0]  CTRL_RESET      = 6'h00;
   localparam logic [23:0] STATUS_RESET    = 24'h800000;
   // Timing.
   localparam int          CLK_MHZ         = 50;
   localparam int          STARTUP_TIME_US = 100;
   localparam int          STARTUP_CYCLES  = STARTUP_TIME_US * CLK_MHZ;
   localparam int          RETRY_SHORT_US  = 20;
   localparam int          RETRY_LONG_US   = 80;
   localparam int          RETRY_CNT_W     = 12;
   localparam logic [11:0] RETRY_SHORT_CYC = 12'(RETRY_SHORT_US * CLK_MHZ - 1);
   localparam logic [11:0] RETRY_LONG_CYC  = 12'(RETRY_LONG_US * CLK_MHZ - 1);
   localparam int          PHASE_BITS      = 6;
   localparam int          BIT_CNT_W       = 5;
   localparam logic [4:0]  LAST_BIT        = 5'h17;
   localparam logic [4:0]  FRAME_DONE      = 5'h18;
endpackage

// ---- rtl/mfsb_spi_link.sv ----
// Serial link shifter running on the link clock.
`timescale 1ns/1ps
module mfsb_spi_link
   import mfsb_pkg::*;
(
   input  wire logic        sclk,
   input  wire logic        resetn,
   input  wire logic        csn,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe,
   input  wire logic [23:0] tx_word,
   output logic [23:0]      rx_word,
   output logic             rx_toggle
);
   logic [BIT_CNT_W-1:0] cnt_r;
   logic [BIT_CNT_W-1:0] cnt_nxt;
   logic [23:0]          rx_sh_r;
   logic [23:0]          rx_sh_nxt;
   logic [23:0]          tx_sh_r;
   logic [23:0]          tx_sh_nxt;
   logic [23:0]          rx_word_r;
   logic [23:0]          rx_word_nxt;
   logic                 tgl_r;
   logic                 tgl_nxt;
   logic                 frame_rstn;

   // Shift state is cleared whenever the chip select is high, so no edge outside a frame is needed.
   assign frame_rstn = resetn & ~csn;

   ////////////////////////////////////////////////////////////////////////////////
   // Sample on rising edge, MSB first; the first bit comes straight from the held word.
   always_comb begin
      cnt_nxt     = cnt_r;
      rx_sh_nxt   = {rx_sh_r[22:0], mosi};
      tx_sh_nxt   = (cnt_r == '0) ? {tx_word[22:0], 1'b0} : {tx_sh_r[22:0], 1'b0};
      rx_word_nxt = rx_word_r;
      tgl_nxt     = tgl_r;
      if (cnt_r != FRAME_DONE) begin
         cnt_nxt = cnt_r + 5'h01;
      end
      if (cnt_r == LAST_BIT) begin
         rx_word_nxt = rx_sh_nxt;
         tgl_nxt     = ~tgl_r;
      end
   end

   always_ff @(posedge sclk or negedge frame_rstn) begin
      if (!frame_rstn) begin
         cnt_r   <= '0;
         rx_sh_r <= '0;
         tx_sh_r <= '0;
      end else begin
         cnt_r   <= cnt_nxt;
         rx_sh_r <= rx_sh_nxt;
         tx_sh_r <= tx_sh_nxt;
      end
   end

   // The finished word and its toggle outlive the frame for the core to collect.
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         rx_word_r <= '0;
         tgl_r     <= 1'b0;
      end else begin
         rx_word_r <= rx_word_nxt;
         tgl_r     <= tgl_nxt;
      end
   end

   assign miso      = (cnt_r == '0) ? tx_word[23] : tx_sh_r[23];
   assign miso_oe   = ~csn;
   assign rx_word   = rx_word_r;
   assign rx_toggle = tgl_r;
endmodule // mfsb_spi_link

// ---- rtl/mfsb_top.sv ----
// Mode control and upper fault status bank behind a serial link.
`timescale 1ns/1ps
module mfsb_top
   import mfsb_pkg::*;
#(
   parameter int STARTUP_CNT = STARTUP_CYCLES
)(
   input  wire logic                  clock,
   input  wire logic                  resetn,
   input  wire logic                  sclk,
   input  wire logic                  csn,
   input  wire logic                  mosi,
   output logic                       miso,
   output logic                       miso_oe,
   input  wire logic [N_RETRY-1:0]    overcurrent_pin,
   input  wire logic                  motor_supply_over_pin,
   input  wire logic                  motor_supply_under_pin,
   input  wire logic                  overtemp_pin,
   input  wire logic                  temp_warning_pin,
   input  wire logic                  retry_duty_long,
   input  wire logic                  fault_clear,
   input  wire logic [LOWER_BITS-1:0] lower_status,
   input  wire logic                  other_fault_any,
   output logic                       active_mode,
   output logic                       outputs_enable,
   output logic                       thermal_shutdown_flag,
   output logic [N_RETRY-1:0]         overcurrent_flag,
   output logic [N_RETRY-1:0]         overcurrent_auto_retry_enable,
   output logic                       load_output_seven,
   output logic                       load_output_eight,
   output logic                       load_output_nine,
   output logic                       load_output_ten,
   output logic                       load_output_eleven
);
   localparam int SYNC_W = N_RETRY + 5;

   logic [SYNC_W-1:0]     sync1_r;
   logic [SYNC_W-1:0]     sync2_r;
   logic [N_RETRY-1:0]    oc_s;
   logic                  ov_s;
   logic                  uv_s;
   logic                  hot_s;
   logic                  warn_s;
   logic                  idle_s;
   logic                  tgl_s1_r;
   logic                  tgl_s2_r;
   logic                  tgl_d_r;
   logic [23:0]           link_word;
   logic                  link_tgl;
   logic                  frame_take;
   logic                  write_reg;
   logic [5:0]            ctrl_r;
   logic [5:0]            ctrl_nxt;
   logic                  nrdy_r;
   logic                  nrdy_nxt;
   logic [31:0]           nrdy_cnt_r;
   logic [31:0]           nrdy_cnt_nxt;
   logic                  shutdown_r;
   logic                  shutdown_nxt;
   logic                  ov_r;
   logic                  uv_r;
   logic                  warn_r;
   logic                  permit_r;
   logic                  permit_nxt;
   logic [PHASE_BITS-1:0] phase_r;
   logic [23:0]           stat_word;
   logic [23:0]           stat_hold_r;
   logic [23:0]           stat_hold_nxt;
   logic [N_RETRY-1:0]    oc_d_r;
   logic [N_RETRY-1:0]    oc_rise;
   logic [N_RETRY-1:0]    off_r;
   logic [N_RETRY-1:0]    flag_r;
   logic [N_RETRY-1:0]    retrying_r;
   logic [N_RETRY-1:0]    chan_on_r;

   // Every check in this module runs on the core clock and rests during reset.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // Returns the start-up count less one at a 32-bit width.
   function automatic logic [31:0] start_load(input int cycles);
      start_load = 32'(cycles - 1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for fault pins, chip select and the frame toggle.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync1_r  <= '0;
         sync2_r  <= '0;
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_d_r  <= 1'b0;
         oc_d_r   <= '0;
      end else begin
         sync1_r  <= {~csn, temp_warning_pin, overtemp_pin, motor_supply_under_pin, motor_supply_over_pin,
                      overcurrent_pin};
         sync2_r  <= sync1_r;
         tgl_s1_r <= link_tgl;
         tgl_s2_r <= tgl_s1_r;
         tgl_d_r  <= tgl_s2_r;
         oc_d_r   <= oc_s;
      end
   end

   assign oc_s       = sync2_r[N_RETRY-1:0];
   assign ov_s       = sync2_r[N_RETRY];
   assign uv_s       = sync2_r[N_RETRY+1];
   assign hot_s      = sync2_r[N_RETRY+2];
   assign warn_s     = sync2_r[N_RETRY+3];
   assign idle_s     = ~sync2_r[N_RETRY+4];
   assign oc_rise    = oc_s & ~oc_d_r;
   assign frame_take = tgl_s2_r ^ tgl_d_r;
   assign write_reg  = frame_take && (link_word[IN_SELECT] == SELECT_THIS_REG);

   ////////////////////////////////////////////////////////////////////////////////
   // Serial shifter on the link clock; the received word is held stable once its toggle flips.
   mfsb_spi_link mfsb_spi_link_inst (
      .sclk      (sclk),
      .resetn    (resetn),
      .csn       (csn),
      .mosi      (mosi),
      .miso      (miso),
      .miso_oe   (miso_oe),
      .tx_word   (stat_hold_r),
      .rx_word   (link_word),
      .rx_toggle (link_tgl)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Control word, start-up timer, thermal latch and the common output permit.
   always_comb begin
      ctrl_nxt     = ctrl_r;
      nrdy_nxt     = nrdy_r;
      nrdy_cnt_nxt = nrdy_cnt_r;
      shutdown_nxt = shutdown_r;
      if (write_reg) begin
         if (link_word[IN_ENABLE]) begin
            ctrl_nxt = {1'b1, link_word[IN_RETRY_HI:IN_RETRY_LO]};
         end else begin
            ctrl_nxt = CTRL_RESET;
         end
      end
      if (ctrl_nxt[5] && !ctrl_r[5]) begin
         nrdy_nxt     = 1'b1;
         nrdy_cnt_nxt = start_load(STARTUP_CNT);
      end else if (!ctrl_r[5]) begin
         nrdy_nxt     = 1'b0;
         nrdy_cnt_nxt = '0;
      end else if (nrdy_r) begin
         if (nrdy_cnt_r == '0) begin
            nrdy_nxt = 1'b0;
         end else begin
            nrdy_cnt_nxt = nrdy_cnt_r - 32'h00000001;
         end
      end
      // A persisting overtemperature wins over the clear.
      if (fault_clear) begin
         shutdown_nxt = 1'b0;
      end
      if (hot_s) begin
         shutdown_nxt = 1'b1;
      end
      // The warning is deliberately left out of the permit.
      permit_nxt = ctrl_r[5] && !nrdy_r && !shutdown_r && !ov_r && !uv_r;
   end

   // Power-on reset leaves the device in standby with everything cleared.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_r     <= CTRL_RESET;
         nrdy_r     <= 1'b0;
         nrdy_cnt_r <= '0;
         shutdown_r <= 1'b0;
         ov_r       <= 1'b0;
         uv_r       <= 1'b0;
         warn_r     <= 1'b0;
         permit_r   <= 1'b0;
         phase_r    <= '0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         nrdy_r     <= nrdy_nxt;
         nrdy_cnt_r <= nrdy_cnt_nxt;
         shutdown_r <= shutdown_nxt;
         ov_r       <= ov_s;
         uv_r       <= uv_s;
         warn_r     <= warn_s;
         permit_r   <= permit_nxt;
         phase_r    <= phase_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-output over-current handling; channel 0 is load output seven.
   for (genvar i = 0; i < N_RETRY; i++) begin : g_chan
      logic [RETRY_CNT_W-1:0] cnt_r;
      logic [RETRY_CNT_W-1:0] cnt_nxt;
      logic                   off_nxt;
      logic                   flag_nxt;
      logic                   retrying_nxt;

      always_comb begin
         cnt_nxt      = cnt_r;
         off_nxt      = off_r[i];
         flag_nxt     = flag_r[i];
         retrying_nxt = retrying_r[i];
         if (fault_clear) begin
            flag_nxt = 1'b0;
            if (!retrying_r[i]) begin
               off_nxt = 1'b0;
            end
         end
         if (retrying_r[i]) begin
            if (cnt_r == '0) begin
               off_nxt      = 1'b0;
               retrying_nxt = 1'b0;
            end else begin
               cnt_nxt = cnt_r - 12'h001;
            end
         end
         if (oc_rise[i] && !off_r[i]) begin
            off_nxt      = 1'b1;
            flag_nxt     = 1'b1;
            retrying_nxt = ctrl_r[i] || phase_r[PHASE_BITS-1];
            cnt_nxt      = retry_duty_long ? RETRY_LONG_CYC : RETRY_SHORT_CYC;
         end
         if (!ctrl_r[5]) begin
            off_nxt      = 1'b0;
            retrying_nxt = 1'b0;
         end
      end

      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            cnt_r         <= '0;
            off_r[i]      <= 1'b0;
            flag_r[i]     <= 1'b0;
            retrying_r[i] <= 1'b0;
            chan_on_r[i]  <= 1'b0;
         end else begin
            cnt_r         <= cnt_nxt;
            off_r[i]      <= off_nxt;
            flag_r[i]     <= flag_nxt;
            retrying_r[i] <= retrying_nxt;
            chan_on_r[i]  <= permit_nxt && !off_nxt;
         end
      end

      a_oc_cutoff: assert property (oc_rise[i] && !off_r[i] && ctrl_r[5]
                                    |=> off_r[i] && flag_r[i] && !chan_on_r[i])
         else $error("over-current did not switch the output off");
      a_retry_return: assert property (retrying_r[i] && cnt_r == '0 && ctrl_r[5] |=> !off_r[i])
         else $error("retry did not re-enable the output");
      a_phase_retry: assert property (oc_rise[i] && !off_r[i] && ctrl_r[5] && phase_r[PHASE_BITS-1]
                                      |=> retrying_r[i])
         else $error("clock phase did not force one retry");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status word; the snapshot for the link only moves while no frame is running.
   always_comb begin
      stat_word               = {1'b1, ov_r, uv_r, shutdown_r, warn_r, nrdy_r, lower_status, 1'b0};
      stat_word[STS_NO_FAULT] = ~(|stat_word[STS_OVERVOLT:1] | other_fault_any);
      stat_hold_nxt           = idle_s ? stat_word : stat_hold_r;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stat_hold_r <= STATUS_RESET;
      end else begin
         stat_hold_r <= stat_hold_nxt;
      end
   end

   assign active_mode                   = ctrl_r[5];
   assign outputs_enable                = permit_r;
   assign thermal_shutdown_flag         = shutdown_r;
   assign overcurrent_flag              = flag_r;
   assign overcurrent_auto_retry_enable = ctrl_r[N_RETRY-1:0];
   assign load_output_seven             = chan_on_r[0];
   assign load_output_eight             = chan_on_r[1];
   assign load_output_nine              = chan_on_r[2];
   assign load_output_ten               = chan_on_r[3];
   assign load_output_eleven            = chan_on_r[4];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the core clock.

   sequence seq_enable_write;
      write_reg && link_word[IN_ENABLE];
   endsequence

   sequence seq_standby_write;
      write_reg && !link_word[IN_ENABLE];
   endsequence

   a_enter_active: assert property (seq_enable_write |=> active_mode ##0 (nrdy_r || $past(active_mode)))
      else $error("enable write did not enter active mode");
   a_enter_standby: assert property (seq_standby_write |=> ctrl_r == CTRL_RESET ##1 !outputs_enable)
      else $error("standby write did not clear the control bits");
   a_mark_bit: assert property (stat_hold_r[STS_MARK])
      else $error("status marker bit not one");
   a_supply_cut: assert property ((ov_r || uv_r) |=> !outputs_enable)
      else $error("supply fault did not disable outputs");
   a_supply_back: assert property (active_mode && !nrdy_r && !shutdown_r && !ov_r && !uv_r |=> outputs_enable)
      else $error("outputs not reactivated");
   a_thermal_set: assert property (hot_s |=> shutdown_r ##1 !outputs_enable)
      else $error("thermal shutdown not latched");
   a_thermal_hold: assert property (shutdown_r && !fault_clear |=> shutdown_r)
      else $error("thermal shutdown flag dropped without reset bit");
   a_warn_only: assert property ($changed(warn_r) && $stable(ov_r) && $stable(uv_r) && $stable(shutdown_r)
                                 && $stable(nrdy_r) && $stable(ctrl_r) |=> $stable(permit_r))
      else $error("warning changed the outputs");
   a_nrdy_start: assert property ($rose(active_mode) |-> nrdy_r ##1 !outputs_enable)
      else $error("not-ready missing after enable");
   a_nrdy_end: assert property (active_mode && nrdy_r && nrdy_cnt_r == '0 |=> !nrdy_r)
      else $error("not-ready did not clear at timer end");
   a_no_fault: assert property (ov_r || uv_r || shutdown_r || other_fault_any |-> !stat_word[STS_NO_FAULT])
      else $error("no-fault bit set while a fault stands");
endmodule // mfsb_top

// ---- sim/mfsb_spi_master.sv ----
// Serial master model that stands in for the controller on the link.
`timescale 1ns/1ps
module mfsb_spi_master (
   input  wire logic miso,
   input  wire logic miso_oe,
   output logic      sclk,
   output logic      csn,
   output logic      mosi
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle state: link clock stands still and the select is high.
   initial begin
      sclk = 1'b0;
      csn  = 1'b1;
      mosi = 1'b0;
   end

   // One full-duplex frame, most significant bit first; half sets the speed.
   task automatic xfer(input logic [23:0] wr, input realtime half, output logic [23:0] rd, output logic bad);
      #3.1;
      csn = 1'b0;
      for (int k = 23; k >= 0; k--) begin
         mosi = wr[k];
         #(half);
         rd[k] = miso_oe ? miso : 1'bx;
         sclk = 1'b1;
         #(half);
         sclk = 1'b0;
      end
      #(half);
      csn  = 1'b1;
      mosi = ~mosi;  // A released line shows the inverse of its last value.
      bad  = (rd === 24'h000000) || (rd === 24'hFFFFFF);
   endtask
endmodule // mfsb_spi_master

// ---- sim/mode_and_fault_status_bank_test.sv ----
// Self-checking testbench for the mode and fault status bank.
`timescale 1ns/1ps
module mode_and_fault_status_bank_test;
   import mfsb_pkg::*;
   localparam int         SU = 40;  // Shortened start-up count.
   logic                  clock, resetn, sclk, csn, mosi, miso, miso_oe, bad;
   logic [N_RETRY-1:0]    oc_pin, oc_flag, retry_en, loads;
   logic                  ov_pin, uv_pin, ot_pin, warn_pin, duty_long, fclr, other_any;
   logic [LOWER_BITS-1:0] lower;
   logic                  active_mode, outputs_enable, shut_flag;
   logic [23:0]           rd;
   int                    fails, samples_checked;

   ////////////////////////////////////////////////////////////////////////////
   // Design and link partner.
   mfsb_top #(.STARTUP_CNT(SU)) mfsb_top_inst (
      .clock(clock), .resetn(resetn), .sclk(sclk), .csn(csn), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
      .overcurrent_pin(oc_pin), .motor_supply_over_pin(ov_pin), .motor_supply_under_pin(uv_pin),
      .overtemp_pin(ot_pin), .temp_warning_pin(warn_pin), .retry_duty_long(duty_long), .fault_clear(fclr),
      .lower_status(lower), .other_fault_any(other_any), .active_mode(active_mode),
      .outputs_enable(outputs_enable), .thermal_shutdown_flag(shut_flag), .overcurrent_flag(oc_flag),
      .overcurrent_auto_retry_enable(retry_en), .load_output_seven(loads[0]), .load_output_eight(loads[1]),
      .load_output_nine(loads[2]), .load_output_ten(loads[3]), .load_output_eleven(loads[4]));
   mfsb_spi_master mfsb_spi_master_inst (.miso(miso), .miso_oe(miso_oe), .sclk(sclk), .csn(csn), .mosi(mosi));

   // Core clock at 50 MHz.
   initial clock = 1'b0;
   always #10 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks.
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Waits whole cycles, then steps off the edge so outputs have settled.
   task automatic waitc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Sends one word and leaves room for it to act before the next frame.
   task automatic frame(input logic [23:0] w);
      mfsb_spi_master_inst.xfer(w, 7.5, rd, bad);
      waitc(8);
   endtask

   // Reads the status word by sending a word that selects the other register.
   task automatic rdst(input string what, input logic [23:0] exp);
      frame(24'h000000);
      chk(what, exp, rd);
      chk("frame valid", 24'h000000, 24'(bad));
   endtask

   // Expected status from fault bits {over, under, thermal, warning, not ready}.
   function automatic logic [23:0] est(input logic [4:0] f);
      logic [21:0] b;
      b = {f, lower};
      return {1'b1, b, ~((|b) | other_any)};
   endfunction

   // Pulses the reset bit input for one cycle.
   task automatic pulse_clear();
      @(posedge clock);
      fclr <= 1'b1;
      @(posedge clock);
      fclr <= 1'b0;
      waitc(4);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the expected run of about 9700 cycles.
   initial begin
      repeat (30000) @(posedge clock);
      fails++;
      tally_and_finish();
   end

   // Main sequence.
   initial begin
      resetn = 1'b0;
      oc_pin = '0;
      {ov_pin, uv_pin, ot_pin, warn_pin, duty_long, fclr, other_any} = '0;
      lower = '0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      waitc(4);
      chk("active", 24'h0, 24'(active_mode));
      chk("loads", 24'h0, 24'(loads));
      rdst("status reset", est(5'h00));
      $display("test reset done");

      frame(24'hFC0001);
      chk("retry en", 24'h1F, 24'(retry_en));
      chk("active", 24'h1, 24'(active_mode));
      chk("outputs", 24'h0, 24'(outputs_enable));
      rdst("not ready", est(5'h01));
      waitc(SU);
      chk("outputs", 24'h1, 24'(outputs_enable));
      chk("loads", 24'h1F, 24'(loads));
      rdst("ready", est(5'h00));
      $display("test enable done");

      // Retry with short and long off time.
      for (int d = 0; d < 2; d++) begin
         @(posedge clock);
         duty_long <= d[0];
         oc_pin    <= 5'h01;
         waitc(8);
         chk("oc flag", 24'h01, 24'(oc_flag));
         chk("loads", 24'h1E, 24'(loads));
         @(posedge clock);
         oc_pin <= 5'h00;
         waitc(d ? 3985 : 985);
         chk("loads off", 24'h1E, 24'(loads));
         waitc(25);
         chk("loads back", 24'h1F, 24'(loads));
         pulse_clear();
         chk("oc flag", 24'h00, 24'(oc_flag));
      end
      $display("test retry done");

      frame(24'h800001);
      chk("retry en", 24'h00, 24'(retry_en));
      @(posedge clock);
      oc_pin <= 5'h02;
      waitc(8);
      chk("oc flag", 24'h02, 24'(oc_flag));
      chk("loads", 24'h1D, 24'(loads));
      @(posedge clock);
      oc_pin <= 5'h00;
      waitc(4100);
      pulse_clear();
      chk("oc flag", 24'h00, 24'(oc_flag));
      chk("loads", 24'h1F, 24'(loads));
      $display("test no retry done");

      for (int s = 0; s < 2; s++) begin
         @(posedge clock);
         ov_pin <= (s == 0);
         uv_pin <= (s == 1);
         waitc(8);
         chk("loads", 24'h00, 24'(loads));
         rdst("supply", est(s ? 5'h08 : 5'h10));
         @(posedge clock);
         ov_pin <= 1'b0;
         uv_pin <= 1'b0;
         waitc(8);
         chk("loads", 24'h1F, 24'(loads));
      end
      $display("test supply done");

      @(posedge clock);
      ot_pin <= 1'b1;
      waitc(8);
      chk("thermal flag", 24'h1, 24'(shut_flag));
      chk("loads", 24'h00, 24'(loads));
      @(posedge clock);
      ot_pin <= 1'b0;
      waitc(8);
      rdst("thermal", est(5'h04));
      chk("loads", 24'h00, 24'(loads));
      pulse_clear();
      chk("thermal flag", 24'h0, 24'(shut_flag));
      chk("loads", 24'h1F, 24'(loads));
      $display("test thermal done");

      @(posedge clock);
      warn_pin <= 1'b1;
      lower    <= 17'h10001;
      waitc(8);
      rdst("warning", est(5'h02));
      chk("loads", 24'h1F, 24'(loads));
      @(posedge clock);
      warn_pin  <= 1'b0;
      lower     <= '0;
      other_any <= 1'b1;
      waitc(4);
      rdst("other fault", est(5'h00));
      @(posedge clock);
      other_any <= 1'b0;
      $display("test flags done");

      // A word for the other register must leave the retry enables alone.
      frame(24'hFC0000);
      chk("retry en", 24'h00, 24'(retry_en));
      frame(24'h7C0001);
      chk("active", 24'h0, 24'(active_mode));
      chk("retry en", 24'h00, 24'(retry_en));
      chk("loads", 24'h00, 24'(loads));
      frame(24'h800001);
      chk("outputs", 24'h0, 24'(outputs_enable));
      $display("test standby done");
      tally_and_finish();
   end
endmodule // mode_and_fault_status_bank_test
